//--- rtl/handoff_gate.sv
// Fires one word transfer and then locks until the far side's ready level drops.
// Assumes the ready level is already synchronised and lags the transfer it reports.
`timescale 1ns/10ps
module handoff_gate (
    input wire logic clk,
    input wire logic ce,
    input wire logic clr,
    input wire logic ready,
    input wire logic local_ok,
    output logic go
);
    logic locked;

    assign go = ce && ready && local_ok && !locked;

    always_ff @(posedge clk) begin
        if (clr) begin
            locked <= 1'b0;
        end else if (ce) begin
            if (go) begin
                locked <= 1'b1;
            end else if (!ready) begin
                locked <= 1'b0;
            end
        end
    end
endmodule : handoff_gate

//--- rtl/host_port_dsp_side.sv
// DSP-side control, status and data word of the byte-wide host parallel port.
// Assumes host-side levels arrive from another clock domain and host-side pulses are synchronous to clk.
// Functional notes
// - Control register is 8-bit read/write on low data byte, upper bits zero.
// - Hardware and software reset clear control; host cannot reach it.
// - Control bits 5 to 7 read zero; software writes zeros there.
// - Bit 0 with receive-full raises receive interrupt request; clear suppresses it.
// - Bit 1 with transmit-empty raises transmit interrupt request.
// - Bit 2 with command pending raises vectored interrupt using host vector number.
// - Bit 3 is DSP flag mirrored to host status, cleared by hardware/software reset.
// - Bit 4 is second DSP flag mirrored to host, cleared likewise.
// - General-purpose flags never cause interrupts; they are polled.
// - Status register is 8-bit read-only on low byte, upper bits zero.
// - Receive-full sets on host word load, clears on DSP data read.
// - Receive-full also clears on host initialize and all four resets.
// - Transmit-empty sets on word move to host, clears on DSP data write.
// - Transmit-empty also sets on host initialize and all four resets.
// - Command pending follows host command request; all four resets clear it.
// - Taking command exception clears request and pending; host may clear too.
// - Status bit 3 shows host flag a, cleared by all resets.
// - Status bit 4 shows host flag b, cleared by all resets.
// - Status bits 5 and 6 always read zero.
// - Hardware and software reset disable port, all shared pins become inputs.
// - DSP side occupies three 24-bit words: control, status, data.
// - Status bit 7 shows host DMA mode enabled; all resets clear it.
// - Each host-driven status bit is synchronised individually before reading.
`timescale 1ns/10ps
module host_port_dsp_side (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic sw_reset,
    input wire logic individual_reset,
    input wire logic stop_reset,
    input wire host_port_pkg::dsp_bus_req_t bus_req,
    output logic [host_port_pkg::DATA_W-1:0] bus_rdata,
    input wire host_port_pkg::host_levels_t host_levels,
    input wire logic host_tx_bytes_full,
    input wire logic [host_port_pkg::DATA_W-1:0] host_tx_bytes,
    input wire logic host_rx_bytes_full,
    input wire logic host_init,
    input wire logic [host_port_pkg::VECTOR_W-1:0] command_vector_number,
    output logic host_tx_taken,
    output logic host_rx_load,
    output logic [host_port_pkg::DATA_W-1:0] host_rx_bytes,
    output logic dsp_to_host_flag_a,
    output logic dsp_to_host_flag_b,
    output logic rx_irq_req,
    output logic tx_irq_req,
    output logic cmd_irq_req,
    output logic [host_port_pkg::VECTOR_W-1:0] cmd_irq_vector,
    input wire logic cmd_irq_ack,
    output logic host_command_clear,
    input wire logic host_mode_select,
    input wire logic [host_port_pkg::PIN_COUNT-1:0] host_pin_drive,
    output logic host_port_active,
    output logic [host_port_pkg::PIN_COUNT-1:0] pin_oe
);
    logic ctrl_reset;
    logic any_reset;
    logic [host_port_pkg::REG_W-1:0] host_port_control;
    logic [host_port_pkg::REG_W-1:0] host_port_status;
    host_port_pkg::host_levels_t levels_s;
    logic rx_word_full;
    logic tx_word_empty;
    logic [host_port_pkg::DATA_W-1:0] dsp_rx_word_reg;
    logic [host_port_pkg::DATA_W-1:0] dsp_tx_word_reg;
    logic rx_go;
    logic tx_go;
    logic cmd_lock;
    logic command_pending;
    logic host_tx_full_s;
    logic host_rx_full_s;
    logic rd_data;
    logic wr_data;
    logic wr_ctrl;

    assign ctrl_reset = srst || sw_reset;
    assign any_reset = ctrl_reset || individual_reset || stop_reset;
    assign rd_data = ce && bus_req.rd && bus_req.addr == host_port_pkg::OFS_DATA;
    assign wr_data = ce && bus_req.wr && bus_req.addr == host_port_pkg::OFS_DATA;
    assign wr_ctrl = ce && bus_req.wr && bus_req.addr == host_port_pkg::OFS_CONTROL;

    // Host-side levels each pass through their own two-stage chain.
    level_sync #(.WIDTH(host_port_pkg::SYNC_W)) u_level_sync (
        .clk(clk),
        .ce(ce),
        .clr(any_reset),
        .async_in(host_levels),
        .sync_out(levels_s)
    );

    level_sync #(.WIDTH(2)) u_buf_sync (
        .clk(clk),
        .ce(ce),
        .clr(any_reset),
        .async_in({host_rx_bytes_full, host_tx_bytes_full}),
        .sync_out({host_rx_full_s, host_tx_full_s})
    );

    handoff_gate u_rx_gate (
        .clk(clk),
        .ce(ce),
        .clr(any_reset),
        .ready(host_tx_full_s),
        .local_ok(!rx_word_full),
        .go(rx_go)
    );

    handoff_gate u_tx_gate (
        .clk(clk),
        .ce(ce),
        .clr(any_reset),
        .ready(!host_rx_full_s),
        .local_ok(!tx_word_empty && !wr_data),
        .go(tx_go)
    );

    // Control register: only the five defined bits are stored.
    always_ff @(posedge clk) begin
        if (ctrl_reset) begin
            host_port_control <= host_port_pkg::CTL_RESET;
        end else if (wr_ctrl) begin
            host_port_control <= bus_req.wdata[host_port_pkg::REG_W-1:0] & host_port_pkg::CTL_WRITABLE;
        end
    end

    assign dsp_to_host_flag_a = host_port_control[host_port_pkg::CTL_FLAG_A];
    assign dsp_to_host_flag_b = host_port_control[host_port_pkg::CTL_FLAG_B];

    // Receive word and its full flag; a host load wins over a same-cycle clear.
    always_ff @(posedge clk) begin
        if (any_reset) begin
            rx_word_full <= host_port_pkg::RX_FULL_RESET;
        end else if (rx_go) begin
            rx_word_full <= 1'b1;
        end else if (ce && (rd_data || host_init)) begin
            rx_word_full <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rx_go) begin
            dsp_rx_word_reg <= host_tx_bytes;
        end
    end

    // Transmit word and its empty flag.
    always_ff @(posedge clk) begin
        if (any_reset) begin
            tx_word_empty <= host_port_pkg::TX_EMPTY_RESET;
        end else if (tx_go || (ce && host_init)) begin
            tx_word_empty <= 1'b1;
        end else if (wr_data) begin
            tx_word_empty <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (wr_data) begin
            dsp_tx_word_reg <= bus_req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            host_rx_bytes <= '0;
        end else if (tx_go) begin
            host_rx_bytes <= dsp_tx_word_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (any_reset) begin
            host_tx_taken <= 1'b0;
            host_rx_load <= 1'b0;
        end else if (ce) begin
            host_tx_taken <= rx_go;
            host_rx_load <= tx_go;
        end
    end

    // Command pending follows the request until the exception is taken.
    assign command_pending = levels_s.host_command_request && !cmd_lock;

    always_ff @(posedge clk) begin
        if (any_reset) begin
            cmd_lock <= 1'b0;
            host_command_clear <= 1'b0;
        end else if (ce) begin
            host_command_clear <= cmd_irq_ack && command_pending;
            if (cmd_irq_ack && command_pending) begin
                cmd_lock <= 1'b1;
            end else if (!levels_s.host_command_request) begin
                cmd_lock <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cmd_irq_vector <= '0;
        end else if (ce) begin
            cmd_irq_vector <= command_vector_number;
        end
    end

    // Only the three transfer sources raise requests; the flags never do.
    assign rx_irq_req = host_port_control[host_port_pkg::CTL_RX_IE] && rx_word_full;
    assign tx_irq_req = host_port_control[host_port_pkg::CTL_TX_IE] && tx_word_empty;
    assign cmd_irq_req = host_port_control[host_port_pkg::CTL_CMD_IE] && command_pending;

    always_comb begin
        host_port_status = '0;
        host_port_status[host_port_pkg::STS_RX_FULL] = rx_word_full;
        host_port_status[host_port_pkg::STS_TX_EMPTY] = tx_word_empty;
        host_port_status[host_port_pkg::STS_CMD_PENDING] = command_pending;
        host_port_status[host_port_pkg::STS_FLAG_A] = levels_s.host_to_dsp_flag_a;
        host_port_status[host_port_pkg::STS_FLAG_B] = levels_s.host_to_dsp_flag_b;
        host_port_status[host_port_pkg::STS_DMA] = levels_s.dma_mode_a || levels_s.dma_mode_b;
    end

    // Three-word read decode; the unused word reads zero.
    always_ff @(posedge clk) begin
        if (srst) begin
            bus_rdata <= '0;
        end else if (ce && bus_req.rd) begin
            unique case (bus_req.addr)
                host_port_pkg::OFS_CONTROL: begin
                    bus_rdata <= {{(host_port_pkg::DATA_W-host_port_pkg::REG_W){1'b0}}, host_port_control};
                end
                host_port_pkg::OFS_STATUS: begin
                    bus_rdata <= {{(host_port_pkg::DATA_W-host_port_pkg::REG_W){1'b0}}, host_port_status};
                end
                host_port_pkg::OFS_DATA: begin
                    bus_rdata <= dsp_rx_word_reg;
                end
                default: begin
                    bus_rdata <= '0;
                end
            endcase
        end
    end

    // Port ownership; hardware or software reset returns every shared pin to an input.
    always_ff @(posedge clk) begin
        if (ctrl_reset) begin
            host_port_active <= 1'b0;
        end else if (ce) begin
            host_port_active <= host_mode_select;
        end
    end

    assign pin_oe = host_port_active ? host_pin_drive : '0;

    sequence s_ctrl_read;
        ce && bus_req.rd && bus_req.addr == host_port_pkg::OFS_CONTROL && !srst;
    endsequence

    sequence s_status_read;
        ce && bus_req.rd && bus_req.addr == host_port_pkg::OFS_STATUS && !srst;
    endsequence

    property p_ctrl_reset;
        @(posedge clk) ctrl_reset |=> host_port_control == 8'h00 && !dsp_to_host_flag_a && !dsp_to_host_flag_b;
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not cleared by reset");

    property p_ctrl_read;
        @(posedge clk) disable iff (srst) s_ctrl_read |=> bus_rdata[23:5] == 19'h0 && bus_rdata[4:0] == $past(host_port_control[4:0]);
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read value wrong");

    property p_status_read;
        @(posedge clk) disable iff (srst) s_status_read |=> bus_rdata[23:8] == 16'h0 && bus_rdata[6:5] == 2'h0;
    endproperty
    a_status_read: assert property (p_status_read) else $error("status reserved bits nonzero");

    property p_rx_irq;
        @(posedge clk) disable iff (srst)
            rx_go && host_port_control[host_port_pkg::CTL_RX_IE] && !any_reset && !wr_ctrl |=> rx_irq_req;
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("receive request missing");

    property p_tx_write;
        @(posedge clk) disable iff (srst) wr_data && !any_reset && !host_init |=> !tx_word_empty ##0 !tx_irq_req;
    endproperty
    a_tx_write: assert property (p_tx_write) else $error("transmit empty not cleared by write");

    property p_rx_read;
        @(posedge clk) disable iff (srst) rd_data && !rx_go |=> !rx_word_full;
    endproperty
    a_rx_read: assert property (p_rx_read) else $error("receive full not cleared by read");

    property p_any_reset;
        @(posedge clk) any_reset |=> tx_word_empty && !rx_word_full && !command_pending && host_port_status[4:3] == 2'h0
            && !host_port_status[host_port_pkg::STS_DMA];
    endproperty
    a_any_reset: assert property (p_any_reset) else $error("reset values of status wrong");

    property p_cmd_ack;
        @(posedge clk) disable iff (srst) ce && cmd_irq_ack && command_pending && !any_reset |=> !command_pending && !cmd_irq_req && host_command_clear;
    endproperty
    a_cmd_ack: assert property (p_cmd_ack) else $error("command not cleared by exception");

    property p_pins_input;
        @(posedge clk) ctrl_reset |=> pin_oe == 15'h0000;
    endproperty
    a_pins_input: assert property (p_pins_input) else $error("pins driven after reset");
endmodule : host_port_dsp_side

//--- rtl/host_port_pkg.sv
// Shared constants and carrier types for the DSP-side host port control and status block.
// Assumes a 24-bit DSP peripheral word bus and a 100 MHz core clock.
package host_port_pkg;
    localparam int DATA_W = 24;
    localparam int ADDR_W = 2;
    localparam int REG_W = 8;
    localparam int PIN_COUNT = 15;
    localparam int VECTOR_W = 6;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 2'h0;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 2'h1;
    localparam logic [ADDR_W-1:0] OFS_DATA = 2'h2;
    localparam int CTL_RX_IE = 0;
    localparam int CTL_TX_IE = 1;
    localparam int CTL_CMD_IE = 2;
    localparam int CTL_FLAG_A = 3;
    localparam int CTL_FLAG_B = 4;
    localparam logic [REG_W-1:0] CTL_WRITABLE = 8'h1F;
    localparam logic [REG_W-1:0] CTL_RESET = 8'h00;
    localparam int STS_RX_FULL = 0;
    localparam int STS_TX_EMPTY = 1;
    localparam int STS_CMD_PENDING = 2;
    localparam int STS_FLAG_A = 3;
    localparam int STS_FLAG_B = 4;
    localparam int STS_DMA = 7;
    localparam logic TX_EMPTY_RESET = 1'h1;
    localparam logic RX_FULL_RESET = 1'h0;
    localparam int SYNC_W = 5;

    typedef struct packed {
        logic dma_mode_b;
        logic dma_mode_a;
        logic host_command_request;
        logic host_to_dsp_flag_b;
        logic host_to_dsp_flag_a;
    } host_levels_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic rd;
        logic wr;
        logic [DATA_W-1:0] wdata;
    } dsp_bus_req_t;
endpackage : host_port_pkg

//--- rtl/level_sync.sv
// Two-flip-flop synchroniser, one chain per bit.
// Assumes each bit is an independent level from the host side of the port.
`timescale 1ns/10ps
module level_sync #(
    parameter int WIDTH = 5
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic clr,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (clr) begin
                stage1[i] <= 1'b0;
                sync_out[i] <= 1'b0;
            end else if (ce) begin
                stage1[i] <= async_in[i];
                sync_out[i] <= stage1[i];
            end
        end
    end
endmodule : level_sync

//--- tb/host_model.sv
// Behavioural host processor on the far side of the host port.
// Assumes the port's pulses are synchronous to clk and driven just after a rising edge.
`timescale 1ns/10ps
module host_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic send,
    input wire logic [23:0] send_word,
    input wire logic cmd_req,
    input wire logic [7:0] rx_hold,
    input wire logic host_tx_taken,
    input wire logic host_rx_load,
    input wire logic [23:0] host_rx_bytes,
    input wire logic host_command_clear,
    output logic host_tx_bytes_full,
    output logic [23:0] host_tx_bytes,
    output logic host_rx_bytes_full,
    output logic host_command_request,
    output logic [23:0] got
);
    logic [7:0] cnt;
    logic cleared;
    assign host_command_request = cmd_req && !cleared;
    always_ff @(posedge clk) begin
        if (srst) begin
            host_tx_bytes_full <= 1'b0;
            host_tx_bytes <= 24'h000000;
        end else if (send && !host_tx_bytes_full) begin
            host_tx_bytes_full <= 1'b1;
            host_tx_bytes <= send_word;
        end else if (host_tx_taken) begin
            host_tx_bytes_full <= 1'b0;
            host_tx_bytes <= ~host_tx_bytes;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            host_rx_bytes_full <= 1'b0;
            cnt <= 8'h00;
        end else if (host_rx_load) begin
            host_rx_bytes_full <= 1'b1;
            got <= host_rx_bytes;
            cnt <= rx_hold;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end else begin
            host_rx_bytes_full <= 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (srst || !cmd_req) begin
            cleared <= 1'b0;
        end else if (host_command_clear) begin
            cleared <= 1'b1;
        end
    end
endmodule : host_model

//--- tb/host_port_dsp_side_control_status_tb.sv
// Self-checking bench for the DSP-side host port control and status block.
// Assumes host_model stands in for the host processor; inputs change at falling edges.
`timescale 1ns/10ps
module host_port_dsp_side_control_status_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] rk = 3'h0;
    logic host_init = 1'b0;
    logic ack = 1'b0;
    logic sel = 1'b0;
    logic ce = 1'b1;
    logic send = 1'b0;
    logic cmd_req = 1'b0;
    logic rd_seen = 1'b0;
    logic [4:0] hl = 5'h00;
    logic [5:0] vec = 6'h00;
    logic [7:0] hold = 8'h00;
    logic [14:0] drv = 15'h0000;
    logic [23:0] sw_word = 24'h000000;
    host_port_pkg::dsp_bus_req_t bus_req = '0;
    logic [23:0] bus_rdata, host_tx_bytes, host_rx_bytes, got;
    logic [14:0] pin_oe;
    logic [5:0] cmd_irq_vector;
    logic host_tx_taken, host_rx_load, flag_a, flag_b, rx_irq_req, tx_irq_req, cmd_irq_req;
    logic host_command_clear, active, tx_full, rx_full, req;
    logic [23:0] exp_q[$];
    logic [23:0] mask_q[$];
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    wire logic [3:0] ev = {host_command_clear, cmd_irq_req, host_rx_load, host_tx_taken};
    always #5 clk = ~clk;
    host_port_dsp_side host_port_dsp_side_inst (.clk(clk), .srst(srst), .ce(ce), .sw_reset(rk[2]),
        .individual_reset(rk[0]), .stop_reset(rk[1]), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .host_levels({hl[4:3], req, hl[1:0]}), .host_tx_bytes_full(tx_full), .host_tx_bytes(host_tx_bytes),
        .host_rx_bytes_full(rx_full), .host_init(host_init), .command_vector_number(vec),
        .host_tx_taken(host_tx_taken), .host_rx_load(host_rx_load), .host_rx_bytes(host_rx_bytes),
        .dsp_to_host_flag_a(flag_a), .dsp_to_host_flag_b(flag_b), .rx_irq_req(rx_irq_req),
        .tx_irq_req(tx_irq_req), .cmd_irq_req(cmd_irq_req), .cmd_irq_vector(cmd_irq_vector),
        .cmd_irq_ack(ack), .host_command_clear(host_command_clear), .host_mode_select(sel),
        .host_pin_drive(drv), .host_port_active(active), .pin_oe(pin_oe));
    host_model host_model_inst (.clk(clk), .srst(srst), .send(send), .send_word(sw_word), .cmd_req(cmd_req),
        .rx_hold(hold), .host_tx_taken(host_tx_taken), .host_rx_load(host_rx_load),
        .host_rx_bytes(host_rx_bytes), .host_command_clear(host_command_clear), .host_tx_bytes_full(tx_full),
        .host_tx_bytes(host_tx_bytes), .host_rx_bytes_full(rx_full), .host_command_request(req), .got(got));
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [23:0] d);
        @(negedge clk);
        bus_req.addr = a;
        bus_req.wdata = d;
        bus_req.wr = 1'b1;
        @(negedge clk);
        bus_req.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [23:0] e, input logic [23:0] m);
        @(negedge clk);
        bus_req.addr = a;
        bus_req.rd = 1'b1;
        exp_q.push_back(e & m);
        mask_q.push_back(m);
        @(negedge clk);
        bus_req.rd = 1'b0;
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // Waits without a local limit; a missing event runs into the global timeout.
    task automatic await(input int w);
        do begin
            @(negedge clk);
        end while (ev[w] !== 1'b1);
    endtask : await
    task automatic pulse_send();
        send = 1'b1;
        cyc(1);
        send = 1'b0;
        await(0);
    endtask : pulse_send
    task automatic wrap_up();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    // Read data is compared against the oldest note in the cycle after the read is taken.
    always @(posedge clk) rd_seen <= bus_req.rd;
    always @(negedge clk) begin
        if (rd_seen === 1'b1 && exp_q.size() > 0) begin
            chk(bus_rdata & mask_q.pop_front(), exp_q.pop_front());
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("MISMATCH t=%0t timeout", $time);
            wrap_up();
        end
    end
    initial begin
        void'($urandom(32'hd2068cc2));
        repeat (16) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        chk(24'(pin_oe), 24'h000000);
        rd(2'h0, 24'h000000, 24'hFFFFFF);
        rd(2'h1, 24'h000002, 24'hFFFFFF);
        rd(2'h3, 24'h000000, 24'hFFFFFF);
        $display("test reset values done");
        wr(2'h0, 24'h000007);
        chk(24'({rx_irq_req, tx_irq_req, cmd_irq_req}), 24'h000002);
        wr(2'h0, 24'h000018);
        chk(24'({flag_b, flag_a, rx_irq_req, tx_irq_req, cmd_irq_req}), 24'h000018);
        repeat (4) begin
            sw_word = 24'($urandom) & 24'hFFFF1F;
            wr(2'h0, sw_word);
            rd(2'h0, sw_word & 24'h00001F, 24'hFFFFFF);
            chk(24'({flag_b, flag_a}), 24'(sw_word[4:3]));
        end
        ce = 1'b0;
        wr(2'h0, ~sw_word & 24'h00001F);
        ce = 1'b1;
        chk(24'({flag_b, flag_a}), 24'(sw_word[4:3]));
        $display("test control done");
        repeat (3) begin
            hl = 5'($urandom) & 5'h1B;
            cyc(4);
            rd(2'h1, {16'h0000, hl[4] | hl[3], 2'h0, hl[1:0], 3'h2}, 24'hFFFFFF);
        end
        hl = 5'h00;
        $display("test host flags done");
        wr(2'h0, 24'h000001);
        sw_word = 24'($urandom);
        pulse_send();
        chk(24'(rx_irq_req), 24'h000001);
        rd(2'h1, 24'h000001, 24'h000001);
        rd(2'h2, sw_word, 24'hFFFFFF);
        rd(2'h1, 24'h000000, 24'h000001);
        wr(2'h0, 24'h000000);
        pulse_send();
        chk(24'(rx_irq_req), 24'h000000);
        host_init = 1'b1;
        cyc(1);
        host_init = 1'b0;
        rd(2'h1, 24'h000002, 24'h000003);
        $display("test host to dsp done");
        hold = 8'h14;
        wr(2'h0, 24'h000002);
        for (int k = 0; k < 2; k++) begin
            sw_word = 24'($urandom);
            wr(2'h2, sw_word);
            chk(24'(tx_irq_req), 24'h000000);
            if (k == 1) begin
                cyc(8);
                chk(24'(tx_irq_req), 24'h000000);
            end
            await(1);
            chk(24'(tx_irq_req), 24'h000001);
            cyc(1);
            chk(got, sw_word);
        end
        $display("test dsp to host done");
        wr(2'h0, 24'h000004);
        vec = 6'($urandom);
        cmd_req = 1'b1;
        await(2);
        chk(24'(cmd_irq_vector), 24'(vec));
        ack = 1'b1;
        cyc(1);
        ack = 1'b0;
        chk(24'({host_command_clear, cmd_irq_req}), 24'h000002);
        cyc(6);
        chk(24'(cmd_irq_req), 24'h000000);
        cmd_req = 1'b0;
        cyc(4);
        cmd_req = 1'b1;
        await(2);
        rd(2'h1, 24'h000004, 24'h000004);
        cmd_req = 1'b0;
        cyc(4);
        rd(2'h1, 24'h000000, 24'h000004);
        $display("test command done");
        sel = 1'b1;
        drv = 15'($urandom);
        cyc(3);
        chk(24'(pin_oe), 24'(drv));
        chk(24'(active), 24'h000001);
        hl = 5'h1B;
        for (int k = 0; k < 3; k++) begin
            wr(2'h0, 24'h00001F);
            pulse_send();
            rk[k] = 1'b1;
            cyc(1);
            chk(24'({active, pin_oe}), k == 2 ? 24'h000000 : {8'h00, 1'b1, drv});
            rk[k] = 1'b0;
            rd(2'h1, 24'h000002, 24'h000003);
            rd(2'h0, k == 2 ? 24'h000000 : 24'h00001F, 24'hFFFFFF);
        end
        $display("test resets done");
        cyc(2);
        wrap_up();
    end
endmodule : host_port_dsp_side_control_status_tb
